// ==== verilog/imlo_defs.svh ====
// constant definitions for the indirect move and literal execution block
`ifndef IMLO_DEFS_SVH
`define IMLO_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// bus register byte offsets, low eight address bits decoded
`define IMLO_OFS_INSTR 8'h00
`define IMLO_OFS_ACC 8'h04
`define IMLO_OFS_PTR0 8'h08
`define IMLO_OFS_PTR1 8'h0C
`define IMLO_OFS_BANK 8'h10
`define IMLO_OFS_OPTION 8'h14
`define IMLO_OFS_STATUS 8'h18
`define IMLO_OFS_POWER 8'h1C

////////////////////////////////////////////////////////////////////////////////
// status and power control field positions
`define IMLO_STAT_ZERO_BIT 0
`define IMLO_STAT_ILL_BIT 1
`define IMLO_PWR_SRST_BIT 0

////////////////////////////////////////////////////////////////////////////////
// fixed encodings and prefixes of the 14-bit instruction word
`define IMLO_ENC_IDLE 14'h0000
`define IMLO_ENC_SRST 14'h0001
`define IMLO_ENC_OPTION 14'h0002
`define IMLO_PFX_IND 10'h001
`define IMLO_PFX_BANK 9'h001
`define IMLO_PFX_STORE 7'h01
`define IMLO_PFX_OFS_RD 7'h7E
`define IMLO_PFX_OFS_WR 7'h7F
`define IMLO_PFX_LIT 4'hC

////////////////////////////////////////////////////////////////////////////////
// field positions inside the instruction word
`define IMLO_IND_WR_BIT 3
`define IMLO_IND_SEL_BIT 2
`define IMLO_OFS_SEL_BIT 6

////////////////////////////////////////////////////////////////////////////////
// reset values
`define IMLO_RST_ACC 8'h00
`define IMLO_RST_PTR 16'h0000
`define IMLO_RST_BANK 5'h00
`define IMLO_RST_OPTION 8'hFF
`define IMLO_RST_SRST_FLAG 1'b1

`endif

// ==== verilog/imlo_pkg.sv ====
// types shared by the indirect move and literal execution block
package imlo_pkg;

  // addressing mode of the indirect moves
  typedef enum logic [1:0] {
    MODE_PRE_INC = 2'h0,
    MODE_PRE_DEC = 2'h1,
    MODE_POST_INC = 2'h2,
    MODE_POST_DEC = 2'h3
  } imlo_mode_t;

  // decoded operation kind
  typedef enum logic [3:0] {
    OP_ILLEGAL = 4'h0,
    OP_IDLE = 4'h1,
    OP_SRST = 4'h2,
    OP_OPTION = 4'h3,
    OP_IND_RD = 4'h4,
    OP_IND_WR = 4'h5,
    OP_BANK = 4'h6,
    OP_STORE = 4'h7,
    OP_LIT = 4'h8
  } imlo_op_t;

  // bus slave phase, gray along idle, read wait, read done
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WR = 2'b10,
    BUS_RD_WAIT = 2'b01,
    BUS_RD_DONE = 2'b11
  } imlo_bus_state_t;

  // decoded instruction fields
  typedef struct packed {
    imlo_op_t op;
    logic ptr_sel;
    imlo_mode_t mode;
    logic use_off;
    logic [5:0] off;
    logic [7:0] lit;
    logic [6:0] file;
  } imlo_decode_t;

  // visible core state
  typedef struct packed {
    logic [7:0] acc;
    logic [4:0] bank;
    logic [7:0] option;
    logic zero;
  } imlo_view_t;

endpackage

// ==== verilog/imlo_ptr_unit.sv ====
// effective address and next pointer value of one indirect access
`timescale 1ns/1ps
`default_nettype none
module imlo_ptr_unit
(
  input wire logic [15:0] ptr,
  input wire imlo_pkg::imlo_mode_t mode,
  input wire logic use_off,
  input wire logic [5:0] off,
  output logic [15:0] eff_addr,
  output logic [15:0] ptr_next
);
  import imlo_pkg::*;

  // sign extension of the six-bit offset
  function automatic logic [15:0] sext6(input logic [5:0] v);
    sext6 = {{10{v[5]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // pointer arithmetic, sixteen bits wrap on their own
  always_comb
  begin
    eff_addr = ptr;
    ptr_next = ptr;
    if (use_off)
    begin
      // offset keeps the pointer
      eff_addr = ptr + sext6(off);
      ptr_next = ptr;
    end
    else
    begin
      case (mode)
        MODE_PRE_INC:
        begin
          eff_addr = ptr + 16'h0001;
          ptr_next = ptr + 16'h0001;
        end
        MODE_PRE_DEC:
        begin
          eff_addr = ptr - 16'h0001;
          ptr_next = ptr - 16'h0001;
        end
        MODE_POST_INC:
        begin
          eff_addr = ptr;
          ptr_next = ptr + 16'h0001;
        end
        MODE_POST_DEC:
        begin
          eff_addr = ptr;
          ptr_next = ptr - 16'h0001;
        end
        default:
        begin
          eff_addr = ptr;
          ptr_next = ptr;
        end
      endcase
    end
  end

endmodule // imlo_ptr_unit
`default_nettype wire

// ==== verilog/imlo_data_mem.sv ====
// byte data memory with one write port and an asynchronous read port
`timescale 1ns/1ps
`default_nettype none
module imlo_data_mem
#(
  parameter int ADDR_W = 8
)
(
  input wire logic hclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [15:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [15:0] raddr,
  output logic [7:0] rdata
);
  import imlo_pkg::*;

  // the array must hold the direct file space and fit a pointer, refused at elaboration
  if (ADDR_W < 7 || ADDR_W > 16)
  begin : g_bad_addr_w
    $error("imlo_data_mem: ADDR_W out of range");
  end

  logic [7:0] mem [0:(1 << ADDR_W) - 1]; // storage, upper address bits alias

  ////////////////////////////////////////////////////////////////////////////////
  // write port, frozen while ce is low
  always_ff @(posedge hclk)
  begin
    if (ce && we)
      mem[waddr[ADDR_W-1:0]] <= wdata;
  end

  // read port
  assign rdata = mem[raddr[ADDR_W-1:0]];

endmodule // imlo_data_mem
`default_nettype wire

// ==== verilog/imlo_core.sv ====
// execution core for indirect moves, literal loads and control instructions
//
// Summary of operation
// RULE1: indirect read loads accumulator, updates zero flag
// RULE2: two-bit mode field selects pre/post inc/dec
// RULE3: pre-increment accesses at pointer plus one
// RULE4: offset mode accesses pointer plus signed offset
// RULE5: pointer ends incremented, decremented or unchanged
// RULE6: post modes access first, then step pointer
// RULE7: indirect data port redirects through its pointer
// RULE8: sixteen-bit pointers wrap at both ends
// RULE9: pointer stepping never touches status flags
// RULE10: indirect write stores accumulator, flags untouched
// RULE11: bank literal loads bank select, no flags
// RULE12: direct store writes file register, no flags
// RULE13: option load copies accumulator, one cycle
// RULE14: software reset resets core, clears flag
// RULE15: literal don't-care bits accepted as zeros
// RULE16: idle op changes nothing for one cycle
// RULE17: one operand bit picks the pointer
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "imlo_defs.svh"
`default_nettype none
module imlo_core
#(
  parameter int MEM_ADDR_W = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic soft_reset_req,
  output imlo_pkg::imlo_view_t core_view
);
  import imlo_pkg::*;

  // the memory must cover the direct file space, refused at elaboration
  if (MEM_ADDR_W < 7 || MEM_ADDR_W > 16)
  begin : g_bad_mem_w
    $error("imlo_core: MEM_ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instruction decode
  function automatic imlo_decode_t decode(input logic [13:0] iw);
    imlo_decode_t d;
    d = '0;
    d.op = OP_ILLEGAL;
    d.mode = imlo_mode_t'(iw[1:0]);
    d.off = iw[5:0];
    d.lit = iw[7:0];
    d.file = iw[6:0];
    if (iw == `IMLO_ENC_IDLE)
      d.op = OP_IDLE;
    else if (iw == `IMLO_ENC_SRST)
      d.op = OP_SRST;
    else if (iw == `IMLO_ENC_OPTION)
      d.op = OP_OPTION;
    else if (iw[13:4] == `IMLO_PFX_IND)
    begin
      // write bit, pointer bit, mode field
      d.op = iw[`IMLO_IND_WR_BIT] ? OP_IND_WR : OP_IND_RD;
      d.ptr_sel = iw[`IMLO_IND_SEL_BIT]; // [RULE17]
    end
    else if (iw[13:7] == `IMLO_PFX_OFS_RD || iw[13:7] == `IMLO_PFX_OFS_WR)
    begin
      // relative offset form
      d.op = (iw[13:7] == `IMLO_PFX_OFS_WR) ? OP_IND_WR : OP_IND_RD;
      d.ptr_sel = iw[`IMLO_OFS_SEL_BIT];
      d.use_off = 1'b1;
    end
    else if (iw[13:5] == `IMLO_PFX_BANK)
      d.op = OP_BANK;
    else if (iw[13:7] == `IMLO_PFX_STORE)
      d.op = OP_STORE;
    else if (iw[13:10] == `IMLO_PFX_LIT)
      d.op = OP_LIT; // bits 9:8 ignored, zeros expected [RULE15]
    decode = d;
  endfunction

  // word read multiplexer
  function automatic logic [31:0] read_mux(input logic [7:0] a, input imlo_view_t v,
                                           input logic [15:0] p0, input logic [15:0] p1,
                                           input logic ill, input logic sflag);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `IMLO_OFS_ACC: r = {24'h000000, v.acc};
      `IMLO_OFS_PTR0: r = {16'h0000, p0};
      `IMLO_OFS_PTR1: r = {16'h0000, p1};
      `IMLO_OFS_BANK: r = {27'h0000000, v.bank};
      `IMLO_OFS_OPTION: r = {24'h000000, v.option};
      `IMLO_OFS_STATUS: r = {30'h00000000, ill, v.zero};
      `IMLO_OFS_POWER: r = {31'h00000000, sflag};
      default: r = 32'h0000_0000;
    endcase
    read_mux = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // declarations
  imlo_bus_state_t bus_state_reg; // slave phase
  imlo_bus_state_t bus_state_next;
  logic [7:0] addr_reg; // latched byte address
  logic [31:0] hrdata_reg; // read data flop
  logic [7:0] acc_reg; // working register
  logic zero_reg; // zero flag
  logic [15:0] ptr0_reg; // file pointer 0
  logic [15:0] ptr1_reg; // file pointer 1
  logic [4:0] bank_reg; // bank select register
  logic [7:0] option_reg; // option configuration register
  logic illegal_reg; // sticky illegal opcode
  logic srst_flag_n_reg; // power control soft reset flag, low after soft reset
  logic soft_reset_req_reg; // reset request pulse
  logic accept; // address phase taken
  logic wr_strobe; // write data phase
  logic issue; // instruction executes this cycle
  imlo_decode_t dec; // current decode
  logic exec_ind; // indirect read or write executes
  logic [15:0] ptr_cur; // selected pointer
  logic [15:0] eff_addr; // indirect effective address
  logic [15:0] ptr_next; // selected pointer after the move
  logic [15:0] file_addr; // direct store target
  logic mem_we; // memory write strobe
  logic [15:0] mem_waddr; // memory write address
  logic [7:0] mem_rdata; // memory read data
  logic [4:0] bank_lit; // bank literal field

  ////////////////////////////////////////////////////////////////////////////////
  // bus slave phase machine
  assign accept = hsel && htrans[1] && hready && ce;
  assign wr_strobe = ce && (bus_state_reg == BUS_WR);
  assign hreadyout = ce && (bus_state_reg != BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // next phase
  always_comb
  begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_RD_WAIT: bus_state_next = BUS_RD_DONE;
      BUS_IDLE, BUS_WR, BUS_RD_DONE:
      begin
        // a new address phase or nothing
        if (accept)
          bus_state_next = hwrite ? BUS_WR : BUS_RD_WAIT;
        else
          bus_state_next = BUS_IDLE;
      end
      default: bus_state_next = BUS_IDLE;
    endcase
  end

  // phase register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bus_state_reg <= BUS_IDLE;
    else if (ce)
      bus_state_reg <= bus_state_next;
  end

  // address latch
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      addr_reg <= 8'h00;
    else if (accept)
      addr_reg <= haddr[7:0];
  end

  // read data taken in the wait cycle, after any preceding write landed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (ce && bus_state_reg == BUS_RD_WAIT)
      hrdata_reg <= read_mux(addr_reg, core_view, ptr0_reg, ptr1_reg, illegal_reg, srst_flag_n_reg);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instruction issue and address generation
  assign issue = wr_strobe && (addr_reg == `IMLO_OFS_INSTR);
  assign dec = decode(hwdata[13:0]);
  assign exec_ind = issue && (dec.op == OP_IND_RD || dec.op == OP_IND_WR);
  assign ptr_cur = dec.ptr_sel ? ptr1_reg : ptr0_reg;
  assign bank_lit = dec.lit[4:0];

  // pointer arithmetic for the selected pointer [RULE2] [RULE3] [RULE4]
  imlo_ptr_unit u_ptr
  (
    .ptr(ptr_cur),
    .mode(dec.mode),
    .use_off(dec.use_off),
    .off(dec.off),
    .eff_addr(eff_addr),
    .ptr_next(ptr_next)
  );

  // direct file address, indirect port locations go through their pointer
  always_comb
  begin
    file_addr = {4'h0, bank_reg, dec.file};
    if (dec.file == 7'h00)
      file_addr = ptr0_reg; // [RULE7]
    else if (dec.file == 7'h01)
      file_addr = ptr1_reg; // [RULE7]
  end

  // memory write port selection [RULE10] [RULE12]
  assign mem_we = issue && (dec.op == OP_IND_WR || dec.op == OP_STORE);
  assign mem_waddr = (dec.op == OP_STORE) ? file_addr : eff_addr;

  // data memory
  imlo_data_mem #(.ADDR_W(MEM_ADDR_W)) u_mem
  (
    .hclk(hclk),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(acc_reg),
    .raddr(eff_addr),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // working register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      acc_reg <= `IMLO_RST_ACC;
    else if (ce)
    begin
      if (issue && dec.op == OP_SRST)
        acc_reg <= `IMLO_RST_ACC; // [RULE14]
      else if (issue && dec.op == OP_IND_RD)
        acc_reg <= mem_rdata; // [RULE1]
      else if (issue && dec.op == OP_LIT)
        acc_reg <= dec.lit; // [RULE15]
      else if (wr_strobe && addr_reg == `IMLO_OFS_ACC)
        acc_reg <= hwdata[7:0];
    end
  end

  // zero flag, only the indirect read and the software reset move it [RULE9]
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      zero_reg <= 1'b0;
    else if (ce)
    begin
      if (issue && dec.op == OP_SRST)
        zero_reg <= 1'b0;
      else if (issue && dec.op == OP_IND_RD)
        zero_reg <= (mem_rdata == 8'h00); // [RULE1]
    end
  end

  // file pointers, wrap by sixteen-bit arithmetic [RULE5] [RULE6] [RULE8]
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ptr0_reg <= `IMLO_RST_PTR;
      ptr1_reg <= `IMLO_RST_PTR;
    end
    else if (ce)
    begin
      if (issue && dec.op == OP_SRST)
      begin
        ptr0_reg <= `IMLO_RST_PTR;
        ptr1_reg <= `IMLO_RST_PTR;
      end
      else if (exec_ind)
      begin
        // only the selected pointer moves [RULE17]
        if (dec.ptr_sel)
          ptr1_reg <= ptr_next;
        else
          ptr0_reg <= ptr_next;
      end
      else if (wr_strobe && addr_reg == `IMLO_OFS_PTR0)
        ptr0_reg <= hwdata[15:0];
      else if (wr_strobe && addr_reg == `IMLO_OFS_PTR1)
        ptr1_reg <= hwdata[15:0];
    end
  end

  // bank select register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bank_reg <= `IMLO_RST_BANK;
    else if (ce)
    begin
      if (issue && dec.op == OP_SRST)
        bank_reg <= `IMLO_RST_BANK;
      else if (issue && dec.op == OP_BANK)
        bank_reg <= bank_lit; // [RULE11]
    end
  end

  // option configuration register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      option_reg <= `IMLO_RST_OPTION;
    else if (ce)
    begin
      if (issue && dec.op == OP_SRST)
        option_reg <= `IMLO_RST_OPTION;
      else if (issue && dec.op == OP_OPTION)
        option_reg <= acc_reg; // [RULE13]
    end
  end

  // sticky illegal opcode, set wins over a write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      illegal_reg <= 1'b0;
    else if (ce)
    begin
      if (issue && dec.op == OP_ILLEGAL)
        illegal_reg <= 1'b1;
      else if (wr_strobe && addr_reg == `IMLO_OFS_STATUS && hwdata[`IMLO_STAT_ILL_BIT])
        illegal_reg <= 1'b0;
    end
  end

  // soft reset flag survives the soft reset, software rewrites it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      srst_flag_n_reg <= `IMLO_RST_SRST_FLAG;
    else if (ce)
    begin
      if (issue && dec.op == OP_SRST)
        srst_flag_n_reg <= 1'b0; // [RULE14]
      else if (wr_strobe && addr_reg == `IMLO_OFS_POWER)
        srst_flag_n_reg <= hwdata[`IMLO_PWR_SRST_BIT];
    end
  end

  // one-cycle reset request to the rest of the device
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      soft_reset_req_reg <= 1'b0;
    else if (ce)
      soft_reset_req_reg <= issue && (dec.op == OP_SRST); // [RULE14]
  end

  assign soft_reset_req = soft_reset_req_reg;
  assign core_view = '{acc: acc_reg, bank: bank_reg, option: option_reg, zero: zero_reg};

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_srst_hit;
    issue && dec.op == OP_SRST;
  endsequence

  sequence s_srst_done;
    soft_reset_req && !srst_flag_n_reg && acc_reg == 8'h00 && ptr0_reg == 16'h0000 && ptr1_reg == 16'h0000;
  endsequence

  sequence s_rd_wait;
    accept && !hwrite ##1 (!hreadyout && ce);
  endsequence

  a_read_zero: assert property (issue && dec.op == OP_IND_RD |=> zero_reg == (acc_reg == 8'h00)) // [RULE1]
    else $error("zero flag does not follow value read");
  a_read_data: assert property (issue && dec.op == OP_IND_RD |=> acc_reg == $past(mem_rdata)) // [RULE1]
    else $error("indirect read did not load accumulator");
  a_pre_inc: assert property (exec_ind && !dec.use_off && dec.mode == MODE_PRE_INC // [RULE3]
                              |-> eff_addr == ptr_cur + 16'h0001)
    else $error("pre-increment address wrong");
  a_post_addr: assert property (exec_ind && !dec.use_off && dec.mode[1] |-> eff_addr == ptr_cur) // [RULE6]
    else $error("post mode did not use current pointer");
  a_offset_keep: assert property (exec_ind && dec.use_off |=> $stable(ptr0_reg) && $stable(ptr1_reg)) // [RULE4]
    else $error("offset mode changed a pointer");
  a_ptr0_step: assert property (exec_ind && !dec.use_off && !dec.ptr_sel && dec.mode[0] == 1'b0 // [RULE5] [RULE2]
                                |=> ptr0_reg == $past(ptr0_reg) + 16'h0001)
    else $error("pointer 0 not incremented");
  a_ptr_wrap: assert property (exec_ind && !dec.use_off && dec.ptr_sel && dec.mode == MODE_POST_DEC && // [RULE8]
                               ptr1_reg == 16'h0000 |=> ptr1_reg == 16'hFFFF)
    else $error("pointer 1 did not wrap");
  a_other_ptr: assert property (exec_ind && dec.ptr_sel |=> $stable(ptr0_reg)) // [RULE17]
    else $error("unselected pointer moved");
  a_flags_kept: assert property (issue && // [RULE9] [RULE10] [RULE12]
                                 dec.op inside {OP_IND_WR, OP_STORE, OP_OPTION, OP_BANK, OP_IDLE}
                                 |=> $stable(zero_reg))
    else $error("status flag changed");
  a_port_redir: assert property (issue && dec.op == OP_STORE && dec.file == 7'h00 // [RULE7]
                                 |-> mem_we && mem_waddr == ptr0_reg)
    else $error("indirect port not redirected");
  a_bank_load: assert property (issue && dec.op == OP_BANK |=> bank_reg == $past(bank_lit)) // [RULE11]
    else $error("bank select not loaded");
  a_option_load: assert property (issue && dec.op == OP_OPTION |=> option_reg == $past(acc_reg)) // [RULE13]
    else $error("option register not loaded");
  a_soft_reset: assert property (s_srst_hit |=> s_srst_done) // [RULE14]
    else $error("soft reset incomplete");
  a_lit_load: assert property (issue && dec.op == OP_LIT |=> acc_reg == $past(hwdata[7:0])) // [RULE15]
    else $error("literal not loaded");
  a_idle_hold: assert property (issue && dec.op == OP_IDLE |=> $stable(acc_reg) && $stable(ptr0_reg) && // [RULE16]
                                $stable(ptr1_reg) && $stable(bank_reg) && $stable(option_reg))
    else $error("idle op changed state");
  a_read_wait: assert property (s_rd_wait |=> (hreadyout || !ce))
    else $error("read wait not one cycle");

endmodule // imlo_core
`default_nettype wire

// ==== sim/test_indirect_move_and_literal_ops.sv ====
// self-checking bench for the indirect move and literal execution core
`timescale 1ns/1ps
`include "imlo_defs.svh"
`default_nettype none
module test_indirect_move_and_literal_ops;
  import imlo_pkg::*;
  // one counted compare, reported at once on mismatch
  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end
  ////////////////////////////////////////////////////////////////////////////////
  logic hclk = 1'b0; // 200 MHz bus clock
  logic hresetn = 1'b0; // async reset, low
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ce = 1'b1; // clock enable, low stalls the core
  wire logic hready; // the one slave drives the bus ready
  wire logic hresp;
  wire logic [31:0] hrdata;
  wire logic soft_reset_req;
  imlo_view_t core_view;
  int failures = 0;
  int n_tests = 0;
  int n_srst = 0; // soft reset pulses seen
  logic [31:0] rd;
  logic [15:0] eff, pexp, base;
  logic [15:0] bases [3] = '{16'h0010, 16'hFFFF, 16'h0000}; // mid, top and bottom of the pointer range
  logic [7:0] val, pa;
  logic zq;
  always #2.5 hclk = ~hclk;
  imlo_core #(.MEM_ADDR_W(8)) uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .soft_reset_req(soft_reset_req), .core_view(core_view));
  // count soft reset request pulses
  always @(posedge hclk)
    if (soft_reset_req === 1'b1)
      n_srst <= n_srst + 1;
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic summarize;
    if (failures == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for ready sampled high at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1)
    begin
      failures++;
      summarize();
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask
  // execute one instruction word
  task automatic ex(input logic [13:0] i);
    wr(`IMLO_OFS_INSTR, {18'h0, i});
  endtask
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    `CHK(nm, e, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd("option", `IMLO_OFS_OPTION, 32'hFF);
    chk_rd("power", `IMLO_OFS_POWER, 32'h1);
    // every mode, both pointers, with wrap at both ends
    foreach (bases[b])
      for (int n = 0; n < 2; n++)
        for (int m = 0; m < 4; m++)
        begin
          base = bases[b];
          val = 8'(m * 8'h55 + b);
          pa = n ? `IMLO_OFS_PTR1 : `IMLO_OFS_PTR0;
          pexp = m[0] ? base - 16'h1 : base + 16'h1;
          eff = m < 2 ? pexp : base;
          wr(pa, {16'h0, base});
          wr(`IMLO_OFS_ACC, {24'h0, val});
          zq = core_view.zero;
          ex(14'h0018 | 14'(n << 2) | 14'(m));
          `CHK("zero kept", zq, core_view.zero)
          chk_rd("ptr step", pa, {16'h0, pexp});
          wr(pa, {16'h0, base});
          ex(14'h3F00 | 14'(n << 6) | 14'(6'(eff - base)));
          chk_rd("acc ofs", `IMLO_OFS_ACC, {24'h0, val});
          `CHK("zero", val == 8'h0, core_view.zero)
          chk_rd("ptr kept", pa, {16'h0, base});
          wr(`IMLO_OFS_ACC, {24'h0, ~val});
          ex(14'h0010 | 14'(n << 2) | 14'(m));
          chk_rd("acc mode", `IMLO_OFS_ACC, {24'h0, val});
          chk_rd("ptr mode", pa, {16'h0, pexp});
        end
    // offset extremes -32 and 31 meet at one byte
    wr(`IMLO_OFS_PTR0, 32'h80);
    wr(`IMLO_OFS_ACC, 32'h77);
    ex(14'h3FA0);
    wr(`IMLO_OFS_PTR1, 32'h41);
    wr(`IMLO_OFS_ACC, 32'h0);
    ex(14'h3F5F);
    chk_rd("acc edge ofs", `IMLO_OFS_ACC, 32'h77);
    chk_rd("ptr0 kept", `IMLO_OFS_PTR0, 32'h80);
    // bank literal 15 then 1, then direct store to file 127
    ex(14'h002F);
    `CHK("bank", 5'hF, core_view.bank)
    ex(14'h0021);
    `CHK("bank", 5'h1, core_view.bank)
    wr(`IMLO_OFS_ACC, 32'h99);
    zq = core_view.zero;
    ex(14'h00FF);
    `CHK("zero store", zq, core_view.zero)
    wr(`IMLO_OFS_PTR0, 32'hFF);
    wr(`IMLO_OFS_ACC, 32'h0);
    ex(14'h3F00);
    chk_rd("acc store", `IMLO_OFS_ACC, 32'h99);
    // store to file 0 lands where pointer 0 points
    wr(`IMLO_OFS_ACC, 32'h3C);
    ex(14'h0080);
    wr(`IMLO_OFS_ACC, 32'h0);
    ex(14'h3F00);
    chk_rd("acc port", `IMLO_OFS_ACC, 32'h3C);
    // literal load, option load, idle
    ex(14'h305A);
    chk_rd("literal", `IMLO_OFS_ACC, 32'h5A);
    wr(`IMLO_OFS_ACC, 32'h4F);
    ex(14'h0002);
    `CHK("option", 8'h4F, core_view.option)
    ex(14'h0000);
    chk_rd("idle acc", `IMLO_OFS_ACC, 32'h4F);
    chk_rd("idle ptr0", `IMLO_OFS_PTR0, 32'hFF);
    // clock enable low stalls a read until it returns
    @(posedge hclk);
    ce <= 1'b0;
    fork
      begin
        repeat (4) @(posedge hclk);
        `CHK("ce stall", 1'b0, hready)
        ce <= 1'b1;
      end
      chk_rd("ce acc", `IMLO_OFS_ACC, 32'h4F);
    join
    // software reset restores state and clears the flag
    ex(14'h0001);
    repeat (2) @(posedge hclk);
    #1;
    `CHK("srst pulse", 1, n_srst)
    chk_rd("power flag", `IMLO_OFS_POWER, 32'h0);
    chk_rd("option rst", `IMLO_OFS_OPTION, 32'hFF);
    chk_rd("ptr0 rst", `IMLO_OFS_PTR0, 32'h0);
    // unmapped read and an illegal opcode
    chk_rd("unmapped", 8'h40, 32'h0);
    ex(14'h0040);
    chk_rd("status", `IMLO_OFS_STATUS, 32'h2);
    // write-one clear of the illegal flag, software rewrite of the power flag
    wr(`IMLO_OFS_STATUS, 32'h2);
    chk_rd("status clr", `IMLO_OFS_STATUS, 32'h0);
    wr(`IMLO_OFS_POWER, 32'h1);
    chk_rd("power set", `IMLO_OFS_POWER, 32'h1);
    summarize();
  end
endmodule // test_indirect_move_and_literal_ops
`default_nettype wire
